// >>> rtl/bp3_cfg.svh
// Purpose: offsets, codes and field positions of the three-port bridge core
// Assumes: included by the package and by every design file
// Notes: byte addresses on the register bus equal the configuration offsets
`ifndef BP3_CFG_SVH
`define BP3_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BP3_OFS_TMR 8'h7C
`define BP3_OFS_CNT 8'h9C
`define BP3_OFS_SLOT 8'hB0
`define BP3_OFS_HS 8'hC0

// ----------------------------------------------------------------
// capability codes, reset values and field positions
// ----------------------------------------------------------------
`define BP3_CAP_SLOT 8'h04
`define BP3_CAP_HS 8'h06
`define BP3_NXT_HS 8'hC0
`define BP3_NXT_END 8'h00
`define BP3_CNT_RST 32'h0000_0000
`define BP3_TMR_LAST 32'h0000_0001
`define BP3_SLOT_MSB 20
`define BP3_SLOT_LSB 16
`define BP3_B_FIC 21
`define BP3_CHAS_MSB 31
`define BP3_CHAS_LSB 24
`define BP3_B_ENMASK 17
`define BP3_B_LED 19

// ----------------------------------------------------------------
// bus commands and port codes
// ----------------------------------------------------------------
`define BP3_CMD_IORD 4'h2
`define BP3_CMD_IOWR 4'h3
`define BP3_CMD_MRD 4'h6
`define BP3_CMD_MWR 4'h7
`define BP3_CMD_CFRD 4'hA
`define BP3_CMD_CFWR 4'hB
`define BP3_CMD_MRDM 4'hC
`define BP3_CMD_MRDL 4'hE
`define BP3_CMD_MWI 4'hF
`define BP3_PORT_PRI 2'h0
`define BP3_PORT_NONE 2'h3

// ----------------------------------------------------------------
// ordering queue shape
// ----------------------------------------------------------------
`define BP3_QDEPTH 4
`define BP3_QCW 3

`endif

// >>> rtl/bp3_pkg.sv
// Purpose: shared types of the three-port bridge core
// Assumes: bp3_cfg.svh gives the sizes
// Notes: transaction classes follow the ordering table of the bridge
`include "bp3_cfg.svh"

package bp3_pkg;

   typedef enum logic [2:0] {
      CLS_PW,
      CLS_DRR,
      CLS_DWR,
      CLS_DRC,
      CLS_DWC
   } bp3_cls_t;

   typedef struct packed {
      bp3_cls_t cls;
      logic [1:0] src;
      logic [3:0] cmd;
      logic [31:0] addr;
   } bp3_ent_t;

   typedef struct packed {
      bp3_ent_t [`BP3_QDEPTH-1:0] ent;
      logic [`BP3_QCW-1:0] cnt;
   } bp3_q_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic [31:0] tmr;
      logic [4:0] slot;
      logic fic;
      logic [7:0] chas;
      logic enmask;
      logic led;
      logic [31:0] dat;
      logic ack;
      bp3_ent_t [2:0] fwd;
      logic [2:0] fwd_v;
      logic [2:0] cpl;
      bp3_ent_t [2:0] hold;
      logic [2:0] hold_v;
      logic [2:0] pend;
      logic [2:0] devsel_n;
      logic [2:0] retry;
      logic [2:0] done;
      logic enum_n;
   } bp3_st_t;

endpackage

// >>> rtl/bp3_ordq.sv
// Purpose: ordering queue of transactions heading to one port
// Assumes: pop only while iss_v_o is high; push refused while full_o
// Notes: issues the oldest entry allowed to pass every older entry
`include "bp3_cfg.svh"

module bp3_ordq (
   // clock, enable, reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // enqueue side
   input wire logic push_i,
   input wire bp3_pkg::bp3_ent_t push_ent_i,
   output logic full_o,
   // issue side
   output logic iss_v_o,
   output bp3_pkg::bp3_ent_t iss_ent_o,
   input wire logic pop_i
);
   import bp3_pkg::*;

   bp3_q_t q_ff;
   bp3_q_t nxt_q;
   logic [`BP3_QDEPTH-1:0] elig;
   logic [`BP3_QCW-1:0] sel;

   // ----------------------------------------------------------------
   // pass table
   // ----------------------------------------------------------------
   function automatic logic may_pass(bp3_cls_t a, bp3_cls_t b, logic b_head);
      case (a)
         CLS_PW: may_pass = (b != CLS_PW) && ((b != CLS_DRR) || b_head);
         CLS_DRR, CLS_DWR: may_pass = (b == CLS_DRC) || (b == CLS_DWC);
         CLS_DRC: may_pass = (b == CLS_DRR) || (b == CLS_DWR);
         CLS_DWC: may_pass = (b == CLS_PW) || (b == CLS_DRR) || (b == CLS_DWR);
         default: may_pass = 1'b0;
      endcase
   endfunction

   assign full_o = (q_ff.cnt == `BP3_QCW'(`BP3_QDEPTH));

   always_comb begin
      nxt_q = q_ff;
      elig = '0;
      sel = '0;
      iss_v_o = 1'b0;
      for (int i = 0; i < `BP3_QDEPTH; i++) begin
         elig[i] = (i < int'(q_ff.cnt));
         for (int j = 0; j < i; j++) begin
            if (!may_pass(q_ff.ent[i].cls, q_ff.ent[j].cls, j == 0)) begin
               elig[i] = 1'b0;
            end
         end
      end
      for (int i = `BP3_QDEPTH - 1; i >= 0; i--) begin
         if (elig[i]) begin
            iss_v_o = 1'b1;
            sel = `BP3_QCW'(i);
         end
      end
      iss_ent_o = q_ff.ent[sel];
      // removal closes the gap so the age order of the rest is kept
      if (pop_i && iss_v_o) begin
         for (int i = 0; i < `BP3_QDEPTH - 1; i++) begin
            if (i >= int'(sel)) begin
               nxt_q.ent[i] = q_ff.ent[i + 1];
            end
         end
         nxt_q.cnt = q_ff.cnt - 1'b1;
      end
      if (push_i && !full_o) begin
         nxt_q.ent[nxt_q.cnt] = push_ent_i;
         nxt_q.cnt = nxt_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= '0;
      end else if (ce_i) begin
         q_ff <= nxt_q;
      end
   end

endmodule

// >>> rtl/bp3_bridge_core.sv
// Purpose: claiming, forwarding and ordering core of a three-port bridge
// Assumes: port 0 primary, 1 first secondary, 2 second secondary;
//    address decode and bus phases are done outside, one start pulse per cycle
// Notes: one outstanding delayed transaction per originating port;
//    completions ride back through the queue of their source port;
//    a busy queue answers retry and never stalls the target bus
`include "bp3_cfg.svh"

module bp3_bridge_core (
   // clock, enable, reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register bus, classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // hot-swap
   input wire logic hot_swap_enable_strap_i,
   input wire logic enum_req_i,
   input wire logic hs_extract_i,
   input wire logic hs_insert_i,
   output logic enum_n_o,
   output logic led_control_output_o,
   // cycle decode per port
   input wire logic [2:0] cyc_start_i,
   input wire logic [2:0][3:0] cyc_cmd_i,
   input wire logic [2:0][31:0] cyc_addr_i,
   input wire logic [2:0][1:0] cyc_dest_i,
   input wire logic primary_device_select_n_i,
   // target response per port
   output logic primary_device_select_n_o,
   output logic first_secondary_device_select_n_o,
   output logic second_secondary_device_select_n_o,
   output logic [2:0] term_retry_o,
   output logic [2:0] term_done_o,
   // forwarding as master per port
   output logic [2:0] fwd_valid_o,
   output logic [2:0][3:0] fwd_cmd_o,
   output logic [2:0][31:0] fwd_addr_o,
   input wire logic [2:0] fwd_done_i
);
   import bp3_pkg::*;

   bp3_st_t st_ff;
   bp3_st_t nxt_st;

   logic [2:0] q_push;
   bp3_ent_t [2:0] q_pent;
   logic [2:0] q_full;
   logic [2:0] q_iss_v;
   bp3_ent_t [2:0] q_iss;
   logic [2:0] q_pop;
   logic [2:0] q_taken;
   logic [31:0] rd_val;
   logic [31:0] wr_val;
   logic [7:0] slot_next;
   logic acc;
   logic cnt_evt;
   logic claim;
   logic [1:0] dst;
   bp3_cls_t cls;

   // ----------------------------------------------------------------
   // command classes
   // ----------------------------------------------------------------
   // other commands are never claimed: their initiator sees master abort
   function automatic logic known_cmd(logic [3:0] c);
      case (c)
         `BP3_CMD_IORD,
         `BP3_CMD_IOWR,
         `BP3_CMD_MRD,
         `BP3_CMD_MWR,
         `BP3_CMD_CFRD,
         `BP3_CMD_CFWR,
         `BP3_CMD_MRDM,
         `BP3_CMD_MRDL,
         `BP3_CMD_MWI: known_cmd = 1'b1;
         default: known_cmd = 1'b0;
      endcase
   endfunction

   // anything claimed that is not a write to memory waits as delayed
   function automatic bp3_cls_t class_of(logic [3:0] c);
      case (c)
         `BP3_CMD_MWR, `BP3_CMD_MWI: class_of = CLS_PW;
         `BP3_CMD_IOWR, `BP3_CMD_CFWR: class_of = CLS_DWR;
         default: class_of = CLS_DRR;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // one ordering queue per destination port
   // ----------------------------------------------------------------
   // a queue per destination, so one busy port never blocks another
   for (genvar g = 0; g < 3; g++) begin : g_q
      bp3_ordq u_q (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .ce_i(ce_i),
         .push_i(q_push[g]),
         .push_ent_i(q_pent[g]),
         .full_o(q_full[g]),
         .iss_v_o(q_iss_v[g]),
         .iss_ent_o(q_iss[g]),
         .pop_i(q_pop[g])
      );
   end

   // ----------------------------------------------------------------
   // register read view
   // ----------------------------------------------------------------
   // strap read live: the chain follows the board setting
   assign slot_next = hot_swap_enable_strap_i ? `BP3_NXT_HS : `BP3_NXT_END;
   // the ack flop stops a second take of a held strobe
   assign acc = wb_cyc_i && wb_stb_i && !st_ff.ack;

   always_comb begin
      case ({wb_adr_i[7:2], 2'b00})
         `BP3_OFS_TMR: rd_val = st_ff.tmr;
         `BP3_OFS_CNT: rd_val = st_ff.cnt;
         `BP3_OFS_SLOT: rd_val = {st_ff.chas, 2'b00, st_ff.fic, st_ff.slot,
                                  slot_next, `BP3_CAP_SLOT};
         `BP3_OFS_HS: rd_val = {8'h00, !hs_insert_i, !hs_extract_i, 2'b00,
                                st_ff.led, 1'b0, st_ff.enmask, 1'b0,
                                `BP3_NXT_END, `BP3_CAP_HS};
         default: rd_val = '0;
      endcase
      // unselected lanes write back what they read
      for (int b = 0; b < 4; b++) begin
         wr_val[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : rd_val[b*8 +: 8];
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      q_push = '0;
      q_pent = '0;
      q_pop = '0;
      q_taken = q_full;
      cnt_evt = 1'b0;
      claim = 1'b0;
      dst = '0;
      cls = CLS_PW;
      // claim and termination strobes stand one cycle
      nxt_st.devsel_n = '1;
      nxt_st.retry = '0;
      nxt_st.done = '0;

      // finished forwards: posted ones retire, delayed ones turn into completions;
      // the result waits in cpl so the valid output stays a plain flop
      for (int d = 0; d < 3; d++) begin
         if (fwd_done_i[d] && st_ff.fwd_v[d]) begin
            nxt_st.fwd_v[d] = 1'b0;
            if (st_ff.fwd[d].cls != CLS_PW) begin
               nxt_st.cpl[d] = 1'b1;
               nxt_st.fwd[d].cls = (st_ff.fwd[d].cls == CLS_DRR) ? CLS_DRC : CLS_DWC;
            end
         end
      end

      // completions travel back through the queue of the originating port;
      // they go first since a stuck completion blocks its source for good
      for (int d = 0; d < 3; d++) begin
         if (st_ff.cpl[d] && !q_taken[st_ff.fwd[d].src]) begin
            q_push[st_ff.fwd[d].src] = 1'b1;
            q_pent[st_ff.fwd[d].src] = st_ff.fwd[d];
            q_taken[st_ff.fwd[d].src] = 1'b1;
            nxt_st.cpl[d] = 1'b0;
         end
      end

      // cycles seen on each port as target;
      // the lower port wins a queue wanted twice in one cycle
      for (int s = 0; s < 3; s++) begin
         dst = cyc_dest_i[s];
         cls = class_of(cyc_cmd_i[s]);
         claim = cyc_start_i[s] && known_cmd(cyc_cmd_i[s])
                 && (dst != 2'(s)) && (dst != `BP3_PORT_NONE)
                 && !((s == 0) && !primary_device_select_n_i);
         if (claim) begin
            nxt_st.devsel_n[s] = 1'b0;
            if (cls == CLS_PW) begin
               if (!q_taken[dst]) begin
                  q_push[dst] = 1'b1;
                  q_pent[dst] = '{cls: cls, src: 2'(s), cmd: cyc_cmd_i[s],
                                  addr: cyc_addr_i[s]};
                  q_taken[dst] = 1'b1;
                  nxt_st.done[s] = 1'b1;
                  cnt_evt = cnt_evt || (s == 0);
               end else begin
                  // queue busy: the initiator comes back later
                  nxt_st.retry[s] = 1'b1;
               end
            end else if (st_ff.hold_v[s] && (st_ff.hold[s].cmd == cyc_cmd_i[s])
                         && (st_ff.hold[s].addr == cyc_addr_i[s])) begin
               nxt_st.done[s] = 1'b1;
               nxt_st.hold_v[s] = 1'b0;
               nxt_st.pend[s] = 1'b0;
            end else begin
               nxt_st.retry[s] = 1'b1;
               // a pending port is retried without a second entry
               if (!st_ff.pend[s] && !q_taken[dst]) begin
                  q_push[dst] = 1'b1;
                  q_pent[dst] = '{cls: cls, src: 2'(s), cmd: cyc_cmd_i[s],
                                  addr: cyc_addr_i[s]};
                  q_taken[dst] = 1'b1;
                  nxt_st.pend[s] = 1'b1;
               end
            end
         end
      end

      // issue from each queue: requests to the bus, completions to the hold slot;
      // a held result waits for the identical repeat of its cycle
      for (int d = 0; d < 3; d++) begin
         if (q_iss_v[d]) begin
            if ((q_iss[d].cls == CLS_DRC) || (q_iss[d].cls == CLS_DWC)) begin
               if (!st_ff.hold_v[d]) begin
                  q_pop[d] = 1'b1;
                  nxt_st.hold[d] = q_iss[d];
                  nxt_st.hold_v[d] = 1'b1;
               end
            end else if (!st_ff.fwd_v[d] && !st_ff.cpl[d]) begin
               q_pop[d] = 1'b1;
               nxt_st.fwd[d] = q_iss[d];
               nxt_st.fwd_v[d] = 1'b1;
               nxt_st.cpl[d] = 1'b0;
            end
         end
      end

      // sampling timer and primary memory write count;
      // the count moves only while the timer runs
      if (st_ff.tmr != '0) begin
         nxt_st.tmr = st_ff.tmr - 1'b1;
         if (st_ff.tmr == `BP3_TMR_LAST) begin
            nxt_st.cnt = `BP3_CNT_RST;
         end else if (cnt_evt) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end

      // hot-swap pins
      // registered so the pin cannot glitch on a mask write
      nxt_st.enum_n = !(enum_req_i && st_ff.enmask);

      // register bus: one wait state, software write wins over counting
      nxt_st.ack = acc;
      if (acc) begin
         nxt_st.dat = rd_val;
         if (wb_we_i) begin
            // read-only fields are left out of this decode
            case ({wb_adr_i[7:2], 2'b00})
               `BP3_OFS_TMR: nxt_st.tmr = wr_val;
               `BP3_OFS_CNT: nxt_st.cnt = wr_val;
               `BP3_OFS_SLOT: begin
                  nxt_st.slot = wr_val[`BP3_SLOT_MSB:`BP3_SLOT_LSB];
                  nxt_st.fic = wr_val[`BP3_B_FIC];
                  nxt_st.chas = wr_val[`BP3_CHAS_MSB:`BP3_CHAS_LSB];
               end
               `BP3_OFS_HS: begin
                  nxt_st.enmask = wr_val[`BP3_B_ENMASK];
                  nxt_st.led = wr_val[`BP3_B_LED];
               end
               default: nxt_st.dat = rd_val;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // enable low freezes all state, reset still acts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.devsel_n <= '1;
         st_ff.enum_n <= 1'b1;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output is a flop of the state struct
   assign wb_dat_o = st_ff.dat;
   assign wb_ack_o = st_ff.ack;
   assign enum_n_o = st_ff.enum_n;
   assign led_control_output_o = st_ff.led;
   assign primary_device_select_n_o = st_ff.devsel_n[0];
   assign first_secondary_device_select_n_o = st_ff.devsel_n[1];
   assign second_secondary_device_select_n_o = st_ff.devsel_n[2];
   assign term_retry_o = st_ff.retry;
   assign term_done_o = st_ff.done;
   assign fwd_valid_o = st_ff.fwd_v;

   always_comb begin
      for (int d = 0; d < 3; d++) begin
         fwd_cmd_o[d] = st_ff.fwd[d].cmd;
         fwd_addr_o[d] = st_ff.fwd[d].addr;
      end
   end

endmodule

// >>> verification/bp3_checker.sv
// Purpose: port-level assertions of the bridge core
// Assumes: one clock domain, ce_i gates every start
// Notes: claims are judged in the cycle after the start pulse
`include "bp3_cfg.svh"

module bp3_checker (
   // clock, enable, reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // hot-swap
   input wire logic enum_req_i,
   input wire logic enum_n_o,
   // target and forwarding sides
   input wire logic [2:0] cyc_start_i,
   input wire logic [2:0][3:0] cyc_cmd_i,
   input wire logic [2:0][1:0] cyc_dest_i,
   input wire logic primary_device_select_n_i,
   input wire logic primary_device_select_n_o,
   input wire logic first_secondary_device_select_n_o,
   input wire logic second_secondary_device_select_n_o,
   input wire logic [2:0] term_retry_o,
   input wire logic [2:0] term_done_o,
   input wire logic [2:0] fwd_valid_o,
   input wire logic [2:0][31:0] fwd_addr_o,
   input wire logic [2:0] fwd_done_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // helpers
   // ----
   logic [2:0] st;
   assign st = cyc_start_i & {3{ce_i}};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_claim(dn, d, r);
      !dn && (d ^ r);
   endsequence
   sequence s_quiet(dn, d, r);
      dn && !d && !r;
   endsequence
   AST_ACK_NEXT: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("register request not answered next cycle");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_PRI_LOCAL: assert property (st[0] && (cyc_dest_i[0] == `BP3_PORT_PRI ||
      !primary_device_select_n_i) |=> s_quiet(primary_device_select_n_o, term_done_o[0],
      term_retry_o[0])) else $error("primary local cycle claimed");
   AST_PRI_NONE: assert property (st[0] && cyc_dest_i[0] == `BP3_PORT_NONE |=>
      s_quiet(primary_device_select_n_o, term_done_o[0], term_retry_o[0]))
      else $error("unmapped primary cycle claimed");
   AST_SEC_IGNORE: assert property (st[1] && cyc_dest_i[1] inside {2'h1, 2'h3} |=>
      s_quiet(first_secondary_device_select_n_o, term_done_o[1], term_retry_o[1]))
      else $error("secondary cycle wrongly claimed");
   AST_PRI_CLAIM: assert property (st[0] && primary_device_select_n_i &&
      cyc_dest_i[0] inside {2'h1, 2'h2} && cyc_cmd_i[0] == `BP3_CMD_MWR |=>
      s_claim(primary_device_select_n_o, term_done_o[0], term_retry_o[0]))
      else $error("primary cycle for secondary not claimed");
   AST_SEC_CLAIM: assert property (st[2] && cyc_dest_i[2] inside {2'h0, 2'h1} &&
      cyc_cmd_i[2] inside {`BP3_CMD_MWR, `BP3_CMD_MRD} |=>
      s_claim(second_secondary_device_select_n_o, term_done_o[2], term_retry_o[2]))
      else $error("secondary cycle for other port not claimed");
   AST_ENUM_MASK: assert property (ce_i && !enum_req_i |=> enum_n_o)
      else $error("enumeration output driven without request");
   AST_FWD_HOLD: assert property (fwd_valid_o[1] && !fwd_done_i[1] |=>
      fwd_valid_o[1] && $stable(fwd_addr_o[1])) else $error("forward dropped early");
endmodule

bind bp3_bridge_core bp3_checker u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .enum_req_i, .enum_n_o, .cyc_start_i, .cyc_cmd_i, .cyc_dest_i,
   .primary_device_select_n_i, .primary_device_select_n_o,
   .first_secondary_device_select_n_o, .second_secondary_device_select_n_o, .term_retry_o,
   .term_done_o, .fwd_valid_o, .fwd_addr_o, .fwd_done_i);

// >>> verification/bp3_tgt_model.sv
// Purpose: far-side targets that complete forwarded cycles
// Assumes: one forwarded cycle per port at a time
// Notes: latency shared by all ports, set by the bench to be prompt or slow
module bp3_tgt_model (
   // clock, reset
   input wire logic clk_i,
   input wire logic rst_i,
   // forwarding handshake
   input wire logic [2:0] fwd_valid_i,
   input wire logic [7:0] lat_i,
   output logic [2:0] fwd_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0][7:0] wait_ff;
   // done is a single pulse; a new count starts right after it while valid stays high
   always_ff @(posedge clk_i) begin
      for (int p = 0; p < 3; p++) begin
         if (rst_i || fwd_done_o[p] || !fwd_valid_i[p]) begin
            fwd_done_o[p] <= 1'b0;
            wait_ff[p] <= 8'h00;
         end else if (wait_ff[p] >= lat_i) begin
            fwd_done_o[p] <= 1'b1;
         end else begin
            wait_ff[p] <= wait_ff[p] + 8'h01;
         end
      end
   end
endmodule

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the bridge core
// Assumes: ce_i held high, far side modelled by bp3_tgt_model
// Notes: register rows first, then claim, counter and ordering cases
`include "bp3_cfg.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bp3_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [3:0] s;
      logic [31:0] w;
      logic h;
      logic [31:0] e;
      logic l;
      logic n;
   } bp3_row_t;
   bp3_row_t rows [10] = '{
      '{8'h9C, 4'h0, 32'h0, 1'b1, 32'h0000_0000, 1'b0, 1'b1},
      '{8'hB0, 4'h0, 32'h0, 1'b1, 32'h0000_C004, 1'b0, 1'b1},
      '{8'hB0, 4'h0, 32'h0, 1'b0, 32'h0000_0004, 1'b0, 1'b1},
      '{8'hC0, 4'h0, 32'h0, 1'b1, 32'h00C0_0006, 1'b0, 1'b1},
      '{8'hB0, 4'hF, 32'hFFFF_FFFF, 1'b1, 32'hFF3F_C004, 1'b0, 1'b1},
      '{8'hB0, 4'h8, 32'h0, 1'b1, 32'h003F_C004, 1'b0, 1'b1},
      '{8'hC0, 4'hF, 32'hFFFF_FFFF, 1'b1, 32'h00CA_0006, 1'b1, 1'b0},
      '{8'hC0, 4'hF, 32'h0, 1'b1, 32'h00C0_0006, 1'b0, 1'b1},
      '{8'h10, 4'hF, 32'hFFFF_FFFF, 1'b1, 32'h0000_0000, 1'b0, 1'b1},
      '{8'h9C, 4'hF, 32'h1234_5678, 1'b1, 32'h1234_5678, 1'b0, 1'b1}};
   logic [3:0] cmds [9] = '{`BP3_CMD_MWR, `BP3_CMD_MWI, `BP3_CMD_MRD, `BP3_CMD_MRDM,
      `BP3_CMD_MRDL, `BP3_CMD_IORD, `BP3_CMD_CFRD, `BP3_CMD_IOWR, `BP3_CMD_CFWR};
   logic clk, rst, cyc, stb, we, ack, strap, enum_req, ext, ins, enum_n, led, pdev;
   logic [7:0] adr, lat;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd;
   logic [2:0] start, dsel_n, retry, done, fvalid, fdone, r;
   logic [2:0][3:0] cmd, fcmd;
   logic [2:0][31:0] addr, faddr;
   logic [2:0][1:0] dest;
   logic [31:0] log [$];
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   bp3_bridge_core dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .hot_swap_enable_strap_i(strap),
      .enum_req_i(enum_req), .hs_extract_i(ext), .hs_insert_i(ins), .enum_n_o(enum_n),
      .led_control_output_o(led), .cyc_start_i(start), .cyc_cmd_i(cmd), .cyc_addr_i(addr),
      .cyc_dest_i(dest), .primary_device_select_n_i(pdev),
      .primary_device_select_n_o(dsel_n[0]), .first_secondary_device_select_n_o(dsel_n[1]),
      .second_secondary_device_select_n_o(dsel_n[2]), .term_retry_o(retry),
      .term_done_o(done), .fwd_valid_o(fvalid), .fwd_cmd_o(fcmd), .fwd_addr_o(faddr),
      .fwd_done_i(fdone));
   bp3_tgt_model u_tgt (.clk_i(clk), .rst_i(rst), .fwd_valid_i(fvalid), .lat_i(lat),
      .fwd_done_o(fdone));

   task automatic summarize();
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // ----
   // bus and cycle drivers
   // ----
   task automatic wb(input logic [7:0] a, input logic [3:0] s, input logic [31:0] w,
         output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= (s != 4'h0);
      adr <= a;
      sel <= s;
      wdat <= w;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic att(input int p, input logic [3:0] c, input logic [31:0] a,
         input logic [1:0] d, output logic [2:0] q);
      @(posedge clk);
      start[p] <= 1'b1;
      cmd[p] <= c;
      addr[p] <= a;
      dest[p] <= d;
      @(posedge clk);
      start[p] <= 1'b0;
      @(posedge clk);
      q = {dsel_n[p], done[p], retry[p]};
   endtask
   // the initiator repeats the identical cycle until it ends normally
   task automatic dly(input int p, input logic [3:0] c, input logic [31:0] a,
         input logic [1:0] d);
      logic [2:0] q;
      int n;
      att(p, c, a, d, q);
      chk("first try", 32'(3'b001), 32'(q));
      n = 0;
      do begin
         repeat (4) @(posedge clk);
         att(p, c, a, d, q);
         n++;
      end while (q !== 3'b010 && n < 60);
      chk("repeat done", 32'(3'b010), 32'(q));
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (fvalid[1] && fdone[1]) log.push_back({fcmd[1], faddr[1][27:0]});
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      {rst, cyc, stb, we, strap, enum_req, pdev} = 7'b1000111;
      {ext, ins, start, adr, sel, wdat, cmd, addr, dest} = '0;
      lat = 8'h02;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         strap <= rows[i].h;
         if (rows[i].s != 4'h0) wb(rows[i].a, rows[i].s, rows[i].w, rd);
         wb(rows[i].a, 4'h0, 32'h0, rd);
         chk("reg", rows[i].e, rd);
         chk("led", 32'(rows[i].l), 32'(led));
         chk("enum_n", 32'(rows[i].n), 32'(enum_n));
      end
      ext <= 1'b1;
      ins <= 1'b1;
      enum_req <= 1'b0;
      wb(8'hC0, 4'h0, 32'h0, rd);
      chk("status", 32'h0000_0006, rd);
      att(0, `BP3_CMD_MWR, 32'h1000, 2'h0, r);
      chk("pri local", 32'(3'b100), 32'(r));
      pdev <= 1'b0;
      att(0, `BP3_CMD_MWR, 32'h1000, 2'h1, r);
      chk("pri watched", 32'(3'b100), 32'(r));
      pdev <= 1'b1;
      att(0, `BP3_CMD_MWR, 32'h1000, 2'h3, r);
      chk("pri none", 32'(3'b100), 32'(r));
      att(1, `BP3_CMD_MWR, 32'h1000, 2'h1, r);
      chk("sec same", 32'(3'b100), 32'(r));
      att(1, `BP3_CMD_MWR, 32'h1000, 2'h3, r);
      chk("sec none", 32'(3'b100), 32'(r));
      att(2, `BP3_CMD_MWR, 32'h1000, 2'h0, r);
      chk("sec post", 32'(3'b010), 32'(r));
      dly(1, `BP3_CMD_MRD, 32'h1100, 2'h2);
      foreach (cmds[i]) begin
         if (i < 2) begin
            att(0, cmds[i], 32'h2000 + 32'(i * 4), 2'h2, r);
            chk("posted", 32'(3'b010), 32'(r));
         end else dly(0, cmds[i], 32'h2000 + 32'(i * 4), 2'h2);
      end
      wb(8'h9C, 4'h0, 32'h0, rd);
      chk("count idle", 32'h1234_5678, rd);
      wb(8'h9C, 4'hF, 32'h0, rd);
      wb(8'h7C, 4'hF, 32'h0000_0050, rd);
      repeat (3) att(0, `BP3_CMD_MWR, 32'h3000, 2'h2, r);
      wb(8'h9C, 4'h0, 32'h0, rd);
      chk("count", 32'h0000_0003, rd);
      repeat (90) @(posedge clk);
      wb(8'h9C, 4'h0, 32'h0, rd);
      chk("count expired", 32'h0, rd);
      lat <= 8'h14;
      log.delete();
      att(0, `BP3_CMD_MWR, 32'h4000, 2'h1, r);
      att(0, `BP3_CMD_MWI, 32'h4004, 2'h1, r);
      dly(0, `BP3_CMD_MRD, 32'h4008, 2'h1);
      chk("fwd count", 32'h0000_0003, 32'(log.size()));
      foreach (log[i]) chk("fwd order", {cmds[i], 28'h000_4000 + 28'(i * 4)}, log[i]);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wb(8'hB0, 4'h0, 32'h0, rd);
      chk("slot after reset", 32'h0000_C004, rd);
      wb(8'h9C, 4'h0, 32'h0, rd);
      chk("count after reset", 32'h0, rd);
      chk("led after reset", 32'h0, 32'(led));
      summarize();
   end
endmodule
